//--- hw/ccor_counter_pair.sv
// one 16-bit counter pair with optional rollover flag and slow rate
`timescale 1ns/100ps
module ccor_counter_pair #(
   parameter int W = 16,
   parameter bit ROLL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic clear,
   input wire logic inc,
   input wire logic inc_slow,
   // state
   output logic [W-1:0] count,
   output logic rollover
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic roll_r;
   logic roll_nxt;
   logic [W:0] sum;
   logic step;

   always_comb begin
      sum = {1'b0, count_r} + {{W{1'b0}}, 1'b1};
      // after a rollover a time counter moves at the slow rate
      step = (ROLL && roll_r) ? inc_slow : inc;
      count_nxt = count_r;
      roll_nxt = roll_r;
      if (clear) begin
         // clear beats a same-cycle increment
         count_nxt = '0;
         roll_nxt = 1'b0;
      end else if (step) begin
         count_nxt = sum[W-1:0];
         // a second rollover drops the flag again
         if (ROLL && sum[W]) begin
            roll_nxt = ~roll_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= '0;
         roll_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         roll_r <= roll_nxt;
      end
   end

   assign count = count_r;
   assign rollover = ROLL ? roll_r : 1'b0;
endmodule // ccor_counter_pair

//--- hw/ccor_regs.sv
// control and status register bank of the charge counter, avalon-mm slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
// What this block does
// - wake threshold selector sits in mode bits 3..1; threshold is 3.84 mV divided by it.
// - selector resets to 7 (0.549 mV); values 1..7 give the table thresholds.
// - temperature/clear bits 7..5 show the sensed temperature step.
// - writing 1 to a clear bit 4..0 zeroes the matching counter.
// - clear bit returns to zero by itself once the counter reset is done.
// - each clear bit acts alone and touches no other counter.
// - both bytes of a counter pair are zeroed together.
// - bit 4 zeroes the charge time counter and its rollover flag.
// - bit 3 zeroes the discharge time counter and its rollover flag.
// - bit 2 zeroes the self-discharge counter.
// - bit 1 zeroes the charge count pair.
// - bit 0 zeroes the discharge count pair.
// - offset is 8-bit two's complement; msb 0 discharge, 1 charge.
// - calibrate when cal bit set, line low or override bit 7 set, and input below wake threshold.
// - valid calibration stores offset and clears cal bit; otherwise cal stays 1.
module ccor_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [ccor_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ccor_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [ccor_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // count events from the measurement logic, same clock
   input wire ccor_pkg::ccor_inc_t count_inc,
   input wire logic charge_time_slow_inc,
   input wire logic discharge_time_slow_inc,
   // asynchronous sensor levels
   input wire logic [ccor_pkg::TEMP_W-1:0] temperature_step_in,
   input wire logic single_wire_line_in,
   input wire logic below_wake_threshold_in,
   // calibration engine
   input wire ccor_pkg::ccor_cal_t cal_result,
   output logic cal_run,
   output logic [ccor_pkg::SEL_W-1:0] wake_threshold_select,
   output logic [ccor_pkg::UV_W-1:0] wake_threshold_voltage_uv
);
   localparam int SYNC_W = ccor_pkg::TEMP_W + 2;

   // synchronisers
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] sync_r;
   logic [ccor_pkg::TEMP_W-1:0] temp_step;
   logic line_level;
   logic below_thr;

   // bus state
   logic wait_r;
   logic wait_nxt;
   logic [ccor_pkg::DATA_W-1:0] rdata_r;
   logic [ccor_pkg::DATA_W-1:0] rdata_nxt;
   logic [6:0] idx;
   logic wr_fire;
   logic [ccor_pkg::REG_W-1:0] wbyte;
   logic [ccor_pkg::REG_W-1:0] rbyte;
   logic [2:0] cnt_sel;
   logic [6:0] cnt_dist;

   // register state
   logic [4:0] clear_r;
   logic [4:0] clear_nxt;
   logic [7:0] offset_r;
   logic [7:0] offset_nxt;
   logic cal_r;
   logic cal_nxt;
   logic override_r;
   logic override_nxt;
   logic [ccor_pkg::SEL_W-1:0] sel_r;
   logic [ccor_pkg::SEL_W-1:0] sel_nxt;
   logic run_r;
   logic run_nxt;
   logic [ccor_pkg::UV_W-1:0] uv_r;
   logic [ccor_pkg::UV_W-1:0] uv_nxt;
   logic cal_ok;

   // counters
   logic [ccor_pkg::CNT_W-1:0] cnt [ccor_pkg::NUM_COUNTERS];
   logic [ccor_pkg::NUM_COUNTERS-1:0] roll;
   logic [ccor_pkg::NUM_COUNTERS-1:0] inc_vec;
   logic [ccor_pkg::NUM_COUNTERS-1:0] slow_vec;

   // two-flop synchronisers, only the second stage is read
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {temperature_step_in, single_wire_line_in, below_wake_threshold_in};
         sync_r <= meta_r;
      end
   end

   assign temp_step = sync_r[SYNC_W-1:2];
   assign line_level = sync_r[1];
   assign below_thr = sync_r[0];

   // bus decode
   assign idx = avs_address[ccor_pkg::ADDR_W-1:2];
   // a write lands only at the edge that shows waitrequest low
   assign wr_fire = avs_write && !wait_r && avs_byteenable[0];
   assign wbyte = avs_writedata[ccor_pkg::REG_W-1:0];

   // counter byte decode: pairs run downward from the top index
   always_comb begin
      cnt_dist = ccor_pkg::IDX_COUNT_TOP - idx;
      cnt_sel = cnt_dist[3:1];
   end

   // read multiplexer, unmapped indices read zero
   always_comb begin
      rbyte = '0;
      case (idx)
         ccor_pkg::IDX_OFFSET: begin
            rbyte = offset_r;
         end
         ccor_pkg::IDX_TEMP_CLEAR: begin
            // temperature step always live, clear bits show pending resets
            rbyte = {temp_step, clear_r};
         end
         ccor_pkg::IDX_MODE: begin
            rbyte[ccor_pkg::MODE_OVERRIDE_BIT] = override_r;
            rbyte[ccor_pkg::MODE_CAL_BIT] = cal_r;
            rbyte[ccor_pkg::MODE_CHG_ROLL_BIT] = roll[ccor_pkg::CLR_CHG_TIME];
            rbyte[ccor_pkg::MODE_DIS_ROLL_BIT] = roll[ccor_pkg::CLR_DIS_TIME];
            rbyte[ccor_pkg::MODE_SEL_LSB +: ccor_pkg::SEL_W] = sel_r;
            rbyte[ccor_pkg::MODE_RSVD_BIT] = 1'b0;
         end
         default: begin
            if (idx >= ccor_pkg::IDX_COUNT_BASE) begin
               rbyte = idx[0] ? cnt[cnt_sel][15:8] : cnt[cnt_sel][7:0];
            end
         end
      endcase
   end

   // one wait cycle per access, then a single acknowledge cycle
   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      if ((avs_read || avs_write) && wait_r) begin
         wait_nxt = 1'b0;
         rdata_nxt = {{(ccor_pkg::DATA_W - ccor_pkg::REG_W){1'b0}}, rbyte};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // clear bits: set by a write of 1, dropped once the reset has been applied
   always_comb begin
      clear_nxt = ccor_pkg::CLEAR_RESET;
      if (wr_fire && idx == ccor_pkg::IDX_TEMP_CLEAR) begin
         // zeros leave other counters alone, temperature bits are dropped
         clear_nxt = wbyte[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         clear_r <= ccor_pkg::CLEAR_RESET;
      end else begin
         clear_r <= clear_nxt;
      end
   end

   // counter pairs, one per clear bit
   assign inc_vec = count_inc;
   always_comb begin
      slow_vec = '0;
      slow_vec[ccor_pkg::CLR_CHG_TIME] = charge_time_slow_inc;
      slow_vec[ccor_pkg::CLR_DIS_TIME] = discharge_time_slow_inc;
   end

   genvar gi;
   generate
      for (gi = 0; gi < ccor_pkg::NUM_COUNTERS; gi++) begin : g_cnt
         // bits 4 and 3 also clear their rollover flag
         // bits 2..0 clear plain counters
         ccor_counter_pair #(
            .W(ccor_pkg::CNT_W),
            .ROLL(gi >= ccor_pkg::CLR_DIS_TIME)
         ) u_pair (
            .clk(clk),
            .rst(rst),
            .clear(clear_r[gi]),
            .inc(inc_vec[gi]),
            .inc_slow(slow_vec[gi]),
            .count(cnt[gi]),
            .rollover(roll[gi])
         );
      end
   endgenerate

   // mode, offset and calibration state
   assign cal_ok = cal_result.done && cal_result.valid;

   always_comb begin
      offset_nxt = offset_r;
      cal_nxt = cal_r;
      override_nxt = override_r;
      sel_nxt = sel_r;
      // host writes first, so a calibration result wins the offset
      if (wr_fire && idx == ccor_pkg::IDX_OFFSET) begin
         offset_nxt = wbyte;
      end
      if (cal_ok) begin
         offset_nxt = cal_result.offset;
         cal_nxt = 1'b0;
         override_nxt = 1'b0;
      end
      // a host write of the cal bit beats the same-cycle completion
      if (wr_fire && idx == ccor_pkg::IDX_MODE) begin
         override_nxt = wbyte[ccor_pkg::MODE_OVERRIDE_BIT];
         cal_nxt = wbyte[ccor_pkg::MODE_CAL_BIT];
         // zero selector is invalid, keep the old one
         if (wbyte[ccor_pkg::MODE_SEL_LSB +: ccor_pkg::SEL_W] != '0) begin
            sel_nxt = wbyte[ccor_pkg::MODE_SEL_LSB +: ccor_pkg::SEL_W];
         end
         // reserved bit 0 and rollover flags are not stored
      end
   end

   // calibration request and threshold lookup
   always_comb begin
      // override lets the line level be ignored
      run_nxt = cal_r && (!line_level || override_r) && below_thr;
      // lookup avoids a divider for the fixed base
      uv_nxt = ccor_pkg::WAKE_UV_TABLE[sel_r];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         offset_r <= ccor_pkg::OFFSET_RESET;
         cal_r <= 1'b0;
         override_r <= 1'b0;
         sel_r <= ccor_pkg::SEL_RESET;
         run_r <= 1'b0;
         uv_r <= '0;
      end else begin
         offset_r <= offset_nxt;
         cal_r <= cal_nxt;
         override_r <= override_nxt;
         sel_r <= sel_nxt;
         run_r <= run_nxt;
         uv_r <= uv_nxt;
      end
   end

   // outputs
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign cal_run = run_r;
   assign wake_threshold_select = sel_r;
   assign wake_threshold_voltage_uv = uv_r;
endmodule // ccor_regs

//--- include/ccor_pkg.sv
// constants and carrier types of the charge counter register bank
package ccor_pkg;
   // bus geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   // register indices, byte address is four times the index
   localparam logic [6:0] IDX_OFFSET = 7'h73;
   localparam logic [6:0] IDX_TEMP_CLEAR = 7'h74;
   localparam logic [6:0] IDX_MODE = 7'h75;
   localparam logic [6:0] IDX_COUNT_BASE = 7'h76;
   localparam logic [6:0] IDX_COUNT_TOP = 7'h7f;
   // mode register fields
   localparam int MODE_OVERRIDE_BIT = 7;
   localparam int MODE_CAL_BIT = 6;
   localparam int MODE_CHG_ROLL_BIT = 5;
   localparam int MODE_DIS_ROLL_BIT = 4;
   localparam int MODE_SEL_LSB = 1;
   localparam int MODE_RSVD_BIT = 0;
   localparam int SEL_W = 3;
   // temperature and clear register fields
   localparam int TEMP_LSB = 5;
   localparam int TEMP_W = 3;
   localparam int NUM_COUNTERS = 5;
   localparam int CNT_W = 16;
   localparam int CLR_DIS_COUNT = 0;
   localparam int CLR_CHG_COUNT = 1;
   localparam int CLR_SELF_DIS = 2;
   localparam int CLR_DIS_TIME = 3;
   localparam int CLR_CHG_TIME = 4;
   // reset values
   localparam logic [2:0] SEL_RESET = 3'h7;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
   localparam logic [4:0] CLEAR_RESET = 5'h00;
   // wake threshold in microvolts, base divided by the selector
   localparam int UV_W = 12;
   localparam logic [11:0] WAKE_BASE_UV = 12'hf00;
   localparam logic [11:0] WAKE_UV_TABLE [8] = '{
      12'h000, WAKE_BASE_UV, 12'h780, 12'h500, 12'h3c0, 12'h300, 12'h280, 12'h225};
   // one increment request per counter, bit order matches the clear bits
   typedef struct packed {
      logic charge_time;
      logic discharge_time;
      logic self_discharge;
      logic charge_count;
      logic discharge_count;
   } ccor_inc_t;
   // result handed back by the calibration engine
   typedef struct packed {
      logic done;
      logic valid;
      logic [7:0] offset;
   } ccor_cal_t;
endpackage

//--- testbench/ccor_host_model.sv
// host controller model issuing register accesses
`timescale 1ns/100ps
module ccor_host_model (
   // clock
   input wire logic clk,
   // avalon-mm master side
   output logic [ccor_pkg::ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [ccor_pkg::DATA_W-1:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [ccor_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 9'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
   end
   // request held until the edge that sees waitrequest low
   task automatic xfer(input bit w, input logic [6:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      logic [7:0] dd;
      dd = (idx == ccor_pkg::IDX_MODE) ? {d[7:1], 1'b0} : d;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h00_0000, dd};
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // idle edge so the next request never doubles an assignment
      @(posedge clk);
   endtask
endmodule // ccor_host_model

//--- testbench/ccor_regs_properties.sv
// port assertions of the charge counter register bank
`timescale 1ns/100ps
module ccor_regs_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus
   input wire logic [ccor_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ccor_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [ccor_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // calibration and threshold
   input wire logic below_wake_threshold_in,
   input wire ccor_pkg::ccor_cal_t cal_result,
   input wire logic cal_run,
   input wire logic [ccor_pkg::SEL_W-1:0] wake_threshold_select,
   input wire logic [ccor_pkg::UV_W-1:0] wake_threshold_voltage_uv
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic mode_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address[8:2] == ccor_pkg::IDX_MODE;
   sel_reset_a: assert property ($fell(rst) |-> wake_threshold_select == 3'h7)
      else $error("selector not 7 after reset");
   volt_table_a: assert property (!$past(rst) |-> wake_threshold_voltage_uv ==
      ccor_pkg::WAKE_UV_TABLE[$past(wake_threshold_select)]) else $error("threshold wrong");
   sel_write_a: assert property (!$stable(wake_threshold_select) |-> $past(mode_wr)
      && wake_threshold_select == $past(avs_writedata[3:1])) else $error("selector moved");
   sel_nonzero_a: assert property (wake_threshold_select != 3'h0)
      else $error("selector zero");
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("no answer in one cycle");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   rdata_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   cal_below_a: assert property (cal_run |-> $past(below_wake_threshold_in, 3))
      else $error("calibration above threshold");
   cal_done_a: assert property (cal_result.done && cal_result.valid |-> ##[1:3] !cal_run)
      else $error("calibration still running");
   cover property (mode_wr);
   cover property (cal_run);
   cover property (cal_result.done && cal_result.valid);
endmodule // ccor_regs_properties

//--- testbench/tb.sv
// self-checking bench for the charge counter register bank
`timescale 1ns/100ps
module tb;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, cal_run;
   logic [8:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   ccor_pkg::ccor_inc_t count_inc;
   logic charge_time_slow_inc, discharge_time_slow_inc;
   logic single_wire_line_in, below_wake_threshold_in;
   logic [2:0] temperature_step_in, wake_threshold_select;
   ccor_pkg::ccor_cal_t cal_result;
   logic [11:0] wake_threshold_voltage_uv;
   logic [7:0] q;
   logic [15:0] cnt [5];
   // threshold in microvolts per selector value, 0 has no threshold
   logic [15:0] uv_exp [8] = '{16'h0000, 16'h0f00, 16'h0780, 16'h0500,
      16'h03c0, 16'h0300, 16'h0280, 16'h0225};
   int miscompares;
   int checks_done;
   ccor_regs DUT (
      .clk(clk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .count_inc(count_inc),
      .charge_time_slow_inc(charge_time_slow_inc),
      .discharge_time_slow_inc(discharge_time_slow_inc),
      .temperature_step_in(temperature_step_in),
      .single_wire_line_in(single_wire_line_in),
      .below_wake_threshold_in(below_wake_threshold_in),
      .cal_result(cal_result),
      .cal_run(cal_run),
      .wake_threshold_select(wake_threshold_select),
      .wake_threshold_voltage_uv(wake_threshold_voltage_uv)
   );
   ccor_host_model host (
      .clk(clk),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input string what, input logic [6:0] idx, input logic [7:0] exp);
      host.xfer(1'b0, idx, 8'h00, q);
      chk(what, exp, q);
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      host.xfer(1'b1, idx, d, q);
   endtask
   task automatic rd_cnts;
      for (int j = 0; j < 5; j++) begin
         rd("count lo", 7'h76 + 7'(2 * j), cnt[j][7:0]);
         rd("count hi", 7'h77 + 7'(2 * j), cnt[j][15:8]);
      end
   endtask
   task automatic t_reset;
      rd("mode", ccor_pkg::IDX_MODE, 8'h0e);
      rd("offset", ccor_pkg::IDX_OFFSET, 8'h00);
      rd("temp", ccor_pkg::IDX_TEMP_CLEAR, 8'ha0);
      rd("unmapped", 7'h10, 8'h00);
      chk("sel pin", 16'h0007, {13'h0000, wake_threshold_select});
      chk("wake uv", 16'h0225, {4'h0, wake_threshold_voltage_uv});
   endtask
   task automatic t_select;
      for (int s = 1; s < 8; s++) begin
         wr(ccor_pkg::IDX_MODE, {4'h0, s[2:0], 1'b1});
         rd("mode sel", ccor_pkg::IDX_MODE, {4'h0, s[2:0], 1'b0});
         chk("sel pin", {13'h0000, s[2:0]}, {13'h0000, wake_threshold_select});
         chk("wake uv", uv_exp[s], {4'h0, wake_threshold_voltage_uv});
      end
      // a zero selector is refused on purpose here
      wr(ccor_pkg::IDX_MODE, 8'h00);
      rd("mode zero", ccor_pkg::IDX_MODE, 8'h0e);
      chk("sel pin", 16'h0007, {13'h0000, wake_threshold_select});
      // a write without byte lane 0 must not land
      host.avs_byteenable <= 4'he;
      wr(ccor_pkg::IDX_MODE, 8'h04);
      host.avs_byteenable <= 4'hf;
      rd("mode lane", ccor_pkg::IDX_MODE, 8'h0e);
   endtask
   task automatic t_clear;
      repeat (3) begin
         count_inc <= 5'h1f;
         @(posedge clk);
         count_inc <= 5'h00;
         @(posedge clk);
      end
      for (int j = 0; j < 5; j++) cnt[j] = 16'h0003;
      wr(ccor_pkg::IDX_TEMP_CLEAR, 8'he0);
      rd("temp ro", ccor_pkg::IDX_TEMP_CLEAR, 8'ha0);
      rd_cnts();
      for (int b = 4; b >= 0; b--) begin
         wr(ccor_pkg::IDX_TEMP_CLEAR, 8'h01 << b);
         cnt[4 - b] = 16'h0000;
         rd("clear bits", ccor_pkg::IDX_TEMP_CLEAR, 8'ha0);
         rd_cnts();
      end
   endtask
   task automatic t_cal;
      wr(ccor_pkg::IDX_OFFSET, 8'h80);
      rd("offset rw", ccor_pkg::IDX_OFFSET, 8'h80);
      chk("cal idle", 8'h00, {7'h00, cal_run});
      wr(ccor_pkg::IDX_MODE, 8'h4e);
      for (int n = 0; n < 20 && cal_run !== 1'b1; n++) @(posedge clk);
      chk("cal run", 8'h01, {7'h00, cal_run});
      // a high line blocks calibration until the override is set
      single_wire_line_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk("cal line", 8'h00, {7'h00, cal_run});
      wr(ccor_pkg::IDX_MODE, 8'hce);
      repeat (2) @(posedge clk);
      chk("cal override", 8'h01, {7'h00, cal_run});
      below_wake_threshold_in <= 1'b0;
      repeat (4) @(posedge clk);
      chk("cal above", 8'h00, {7'h00, cal_run});
      below_wake_threshold_in <= 1'b1;
      single_wire_line_in <= 1'b0;
      // a done but invalid calibration result must leave the request pending
      cal_result <= 10'h200;
      @(posedge clk);
      cal_result <= 10'h000;
      @(posedge clk);
      rd("cal pending", ccor_pkg::IDX_MODE, 8'hce);
      cal_result <= 10'h39c;
      @(posedge clk);
      cal_result <= 10'h000;
      @(posedge clk);
      rd("offset cal", ccor_pkg::IDX_OFFSET, 8'h9c);
      rd("cal done", ccor_pkg::IDX_MODE, 8'h0e);
   endtask
   task automatic t_roll;
      count_inc <= 5'h18;
      repeat (65536) @(posedge clk);
      count_inc <= 5'h00;
      @(posedge clk);
      // after a rollover only the slow pulse moves a time counter
      count_inc <= 5'h18;
      charge_time_slow_inc <= 1'b1;
      @(posedge clk);
      count_inc <= 5'h00;
      charge_time_slow_inc <= 1'b0;
      @(posedge clk);
      rd("slow charge", 7'h76, 8'h01);
      rd("slow discharge", 7'h78, 8'h00);
      rd("flags", ccor_pkg::IDX_MODE, 8'h3e);
      wr(ccor_pkg::IDX_TEMP_CLEAR, 8'h10);
      rd("charge flag", ccor_pkg::IDX_MODE, 8'h1e);
      wr(ccor_pkg::IDX_TEMP_CLEAR, 8'h08);
      rd("discharge flag", ccor_pkg::IDX_MODE, 8'h0e);
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      count_inc = 5'h00;
      charge_time_slow_inc = 1'b0;
      discharge_time_slow_inc = 1'b0;
      temperature_step_in = 3'h5;
      single_wire_line_in = 1'b0;
      below_wake_threshold_in = 1'b1;
      cal_result = 10'h000;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_select();
      t_clear();
      t_cal();
      t_roll();
      tally_and_finish();
   end
   // rollover run dominates, about 66k cycles
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
endmodule // tb
bind ccor_regs ccor_regs_properties chk_i (
   .clk(clk),
   .rst(rst),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .below_wake_threshold_in(below_wake_threshold_in),
   .cal_result(cal_result),
   .cal_run(cal_run),
   .wake_threshold_select(wake_threshold_select),
   .wake_threshold_voltage_uv(wake_threshold_voltage_uv)
);
